// ===== rtl/sfuc_commander.sv
// byte command interpreter for field update of the on-chip flash
// assumes a byte-wide serial channel outside (rx strobe, tx handshake)
// and a flash engine that erases, programs pages and reads bytes
//
// Overview of operation
// - 55 opens session, AA requests read
// - in session: 77 erase, 88 program, 99 close
// - replies: 00 success, 01 failure, 11 request
// - wait write enable, then one request
// - program or erase failure: reply, halt forever
// - session open answered with a request
// - zero, bit0 or bits15-12 mask: fail, halt
// - erase finished: reply success
// - request before program data is sent
// - write per 256 bytes, pad short page
// - request after each page until size met
// - size reached: reply success
// - close command returns to top-level idle
// - read: request, eight header bytes, stream data
// - read address beyond flash: fail, halt
// - never program or erase the boot block
// - 9600 baud 8N1, divisor 129 at 40MHz
// - data staged in a 256-byte buffer

`timescale 1ns/1ns

module sfuc_commander
  import sfuc_pkg::*;
#(
  parameter int PAGE = sfuc_pkg::PAGE_BYTES,
  parameter int IW   = $clog2(PAGE)
) (
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic          flash_write_enable_flag,
  input  wire logic          rx_valid,
  input  wire logic [7:0]    rx_data,
  input  wire logic          tx_ready,
  output logic               tx_valid,
  output logic      [7:0]    tx_data,
  output logic      [7:0]    bit_rate_divisor,
  output logic               erase_req,
  output logic      [15:0]   erase_mask,
  input  wire logic          erase_done,
  input  wire logic          erase_fail,
  output logic               prog_req,
  output logic      [31:0]   prog_addr,
  input  wire logic          prog_done,
  input  wire logic          prog_fail,
  input  wire logic [IW-1:0] page_rd_addr,
  output logic      [7:0]    page_rd_data,
  output logic               read_req,
  output logic      [31:0]   read_addr,
  input  wire logic          read_valid,
  input  wire logic [7:0]    read_data,
  output logic               halted
);

  import sfuc_pkg::*;

  sfuc_state_t   state_r, state_nxt;
  sfuc_state_t   ret_r, ret_nxt;
  logic          tx_pend_r, tx_pend_nxt;
  logic [7:0]    tx_byte_r, tx_byte_nxt;
  logic [63:0]   hdr_r, hdr_nxt;
  logic [2:0]    cnt_r, cnt_nxt;
  logic [IW-1:0] idx_r, idx_nxt;
  logic [31:0]   left_r, left_nxt;
  logic [31:0]   addr_r, addr_nxt;
  logic          ereq_r, ereq_nxt;
  logic          preq_r, preq_nxt;
  logic          rreq_r, rreq_nxt;
  logic [7:0]    div_r;
  logic          go_send;
  logic [7:0]    go_byte;
  sfuc_state_t   go_ret;
  logic          buf_we;
  logic [7:0]    buf_wd;

  // ==========================================================
  // decodes of the header and range checks
  wire [63:0] hdr_shift = {hdr_r[55:0], rx_data};
  wire [15:0] mask_w    = hdr_r[15:0];
  wire        mask_bad  = (mask_w == 16'h0000) ||
                          ((mask_w & MASK_BAD_BITS) != 16'h0000);
  wire [31:0] hdr_addr  = hdr_r[63:32];
  wire [31:0] hdr_size  = hdr_r[31:0];
  wire [32:0] prog_end  = {1'b0, hdr_addr} + {1'b0, hdr_size};
  wire        prog_bad  = (hdr_addr < PROG_ADDR_LO) ||
                          (prog_end > PROG_END_MAX);
  wire        read_bad  = hdr_addr > FLASH_ADDR_HI;
  wire        idx_last  = &idx_r;

  // ==========================================================
  // sequencer next state
  always_comb
  begin
    state_nxt   = state_r;
    ret_nxt     = ret_r;
    tx_pend_nxt = tx_pend_r;
    tx_byte_nxt = tx_byte_r;
    hdr_nxt     = hdr_r;
    cnt_nxt     = cnt_r;
    idx_nxt     = idx_r;
    left_nxt    = left_r;
    addr_nxt    = addr_r;
    ereq_nxt    = 1'b0;
    preq_nxt    = 1'b0;
    rreq_nxt    = 1'b0;
    go_send     = 1'b0;
    go_byte     = SUCCESS_REPLY;
    go_ret      = ST_IDLE;
    buf_we      = 1'b0;
    buf_wd      = rx_data;
    case (state_r)
      ST_WAIT_WE:
        if (flash_write_enable_flag)
        begin
          go_send = 1'b1;
          go_byte = SEND_REQUEST_REPLY;
        end
      ST_IDLE:
        if (rx_valid && rx_data == CMD_SESSION_OPEN)
        begin
          go_send = 1'b1;
          go_byte = SEND_REQUEST_REPLY;
          go_ret  = ST_SESSION;
        end
        else if (rx_valid && rx_data == CMD_FLASH_READ)
        begin
          go_send = 1'b1;
          go_byte = SEND_REQUEST_REPLY;
          go_ret  = ST_RHDR;
          cnt_nxt = '0;
        end
      // other bytes fall through and are dropped
      ST_SESSION:
        if (rx_valid)
        begin
          cnt_nxt = '0;
          if (rx_data == CMD_ERASE)
            state_nxt = ST_MASK;
          else if (rx_data == CMD_PROGRAM)
            state_nxt = ST_PHDR;
          else if (rx_data == SESSION_CLOSE_CMD)
            state_nxt = ST_IDLE;
        end
      ST_MASK:
        if (rx_valid)
        begin
          hdr_nxt = hdr_shift;
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_r == MASK_LAST_BYTE)
            state_nxt = ST_ECHK;
        end
      ST_ECHK:
        // block 0 bit rejected with the other illegal bits
        if (mask_bad)
        begin
          go_send = 1'b1;
          go_byte = FAILURE_REPLY;
          go_ret  = ST_HALT;
        end
        else
        begin
          ereq_nxt  = 1'b1;
          state_nxt = ST_ERASE;
        end
      ST_ERASE:
        if (erase_done)
        begin
          go_send = 1'b1;
          go_byte = erase_fail ? FAILURE_REPLY : SUCCESS_REPLY;
          go_ret  = erase_fail ? ST_HALT : ST_SESSION;
        end
      ST_PHDR, ST_RHDR:
        if (rx_valid)
        begin
          hdr_nxt = hdr_shift;
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_r == HDR_LAST_BYTE)
            state_nxt = (state_r == ST_PHDR) ? ST_PCHK : ST_RCHK;
        end
      ST_PCHK:
      begin
        addr_nxt = hdr_addr;
        left_nxt = hdr_size;
        idx_nxt  = '0;
        go_send  = 1'b1;
        if (prog_bad)
        begin
          go_byte = FAILURE_REPLY;
          go_ret  = ST_HALT;
        end
        else if (hdr_size == 32'h0)
          go_ret = ST_SESSION;
        else
        begin
          go_byte = SEND_REQUEST_REPLY;
          go_ret  = ST_PDATA;
        end
      end
      ST_PDATA:
        if (rx_valid)
        begin
          buf_we   = 1'b1;
          idx_nxt  = idx_r + 1'b1;
          left_nxt = left_r - 32'h1;
          if (idx_last)
          begin
            preq_nxt  = 1'b1;
            state_nxt = ST_PWRITE;
          end
          else if (left_r == 32'h1)
            state_nxt = ST_PFILL;
        end
      ST_PFILL:
      begin
        // pad rest of a short page so the whole unit is defined
        buf_we  = 1'b1;
        buf_wd  = PAD_BYTE;
        idx_nxt = idx_r + 1'b1;
        if (idx_last)
        begin
          preq_nxt  = 1'b1;
          state_nxt = ST_PWRITE;
        end
      end
      ST_PWRITE:
        if (prog_done)
        begin
          addr_nxt = addr_r + 32'(PAGE);
          go_send  = 1'b1;
          if (prog_fail)
          begin
            go_byte = FAILURE_REPLY;
            go_ret  = ST_HALT;
          end
          else if (left_r == 32'h0)
            go_ret = ST_SESSION;
          else
          begin
            go_byte = SEND_REQUEST_REPLY;
            go_ret  = ST_PDATA;
          end
        end
      ST_RCHK:
      begin
        addr_nxt = hdr_addr;
        left_nxt = hdr_size;
        if (read_bad)
        begin
          go_send = 1'b1;
          go_byte = FAILURE_REPLY;
          go_ret  = ST_HALT;
        end
        else if (hdr_size == 32'h0)
          state_nxt = ST_IDLE;
        else
          state_nxt = ST_RREQ;
      end
      ST_RREQ:
      begin
        rreq_nxt  = 1'b1;
        state_nxt = ST_RWAIT;
      end
      ST_RWAIT:
        if (read_valid)
        begin
          addr_nxt = addr_r + 32'h1;
          left_nxt = left_r - 32'h1;
          go_send  = 1'b1;
          go_byte  = read_data;
          go_ret   = (left_r == 32'h1) ? ST_IDLE : ST_RREQ;
        end
      ST_SEND:
        if (tx_ready)
        begin
          tx_pend_nxt = 1'b0;
          state_nxt   = ret_r;
        end
      ST_HALT:
        state_nxt = ST_HALT;
      default:
        state_nxt = ST_WAIT_WE;
    endcase
    // every reply goes through one send stage, one byte at a time
    if (go_send)
    begin
      tx_pend_nxt = 1'b1;
      tx_byte_nxt = go_byte;
      ret_nxt     = go_ret;
      state_nxt   = ST_SEND;
    end
  end

  // ==========================================================
  // sequencer registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_r   <= ST_WAIT_WE;
      ret_r     <= ST_IDLE;
      tx_pend_r <= 1'b0;
      tx_byte_r <= 8'h00;
      hdr_r     <= 64'h0;
      cnt_r     <= 3'h0;
      idx_r     <= '0;
      left_r    <= 32'h0;
      addr_r    <= 32'h0;
      ereq_r    <= 1'b0;
      preq_r    <= 1'b0;
      rreq_r    <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      ret_r     <= ret_nxt;
      tx_pend_r <= tx_pend_nxt;
      tx_byte_r <= tx_byte_nxt;
      hdr_r     <= hdr_nxt;
      cnt_r     <= cnt_nxt;
      idx_r     <= idx_nxt;
      left_r    <= left_nxt;
      addr_r    <= addr_nxt;
      ereq_r    <= ereq_nxt;
      preq_r    <= preq_nxt;
      rreq_r    <= rreq_nxt;
    end
  end

  // line divisor for the external serial channel
  always_ff @(posedge core_clk)
  begin
    if (reset)
      div_r <= 8'h00;
    else
      div_r <= BIT_RATE_DIV;
  end

  // ==========================================================
  // staging buffer, drained by the flash engine
  sfuc_page_mem #(
    .DEPTH (PAGE),
    .WIDTH (8)
  ) u_page_staging_buffer (
    .core_clk  (core_clk),
    .reset     (reset),
    .wr_en     (buf_we),
    .wr_addr   (idx_r),
    .wr_data   (buf_wd),
    .rd_addr   (page_rd_addr),
    .rd_data_r (page_rd_data)
  );

  // outputs
  assign tx_valid         = tx_pend_r;
  assign tx_data          = tx_byte_r;
  assign bit_rate_divisor = div_r;
  assign erase_req        = ereq_r;
  assign erase_mask       = mask_w;
  assign prog_req         = preq_r;
  assign prog_addr        = addr_r;
  assign read_req         = rreq_r;
  assign read_addr        = addr_r;
  assign halted           = (state_r == ST_HALT);

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_no_tx_early: assert property (
    state_r == ST_WAIT_WE |-> !tx_valid)
    else $error("byte sent before write enable");
  chk_open_request: assert property (
    state_r == ST_IDLE && rx_valid && rx_data == CMD_SESSION_OPEN
    |=> tx_valid && tx_data == SEND_REQUEST_REPLY && ret_r == ST_SESSION)
    else $error("session open not answered");
  chk_idle_silent: assert property (
    state_r == ST_IDLE && rx_valid && rx_data != CMD_SESSION_OPEN &&
    rx_data != CMD_FLASH_READ |=> state_r == ST_IDLE && !tx_valid)
    else $error("stray byte answered");
  chk_bad_mask: assert property (
    state_r == ST_ECHK && mask_bad
    |=> tx_data == FAILURE_REPLY && ret_r == ST_HALT && !erase_req)
    else $error("illegal mask not refused");
  chk_erase_ok: assert property (
    state_r == ST_ERASE && erase_done && !erase_fail
    |=> tx_valid && tx_data == SUCCESS_REPLY)
    else $error("erase success not reported");
  chk_halt_final: assert property (
    halted |=> halted && !tx_valid && !erase_req && !prog_req)
    else $error("activity after halt");
  chk_halt_entry: assert property (
    $rose(halted) |-> $past(tx_data) == FAILURE_REPLY)
    else $error("halt without failure reply");
  chk_page_whole: assert property (
    prog_req |-> idx_r == '0 && $past(idx_r) == IW'(PAGE - 1))
    else $error("page written before full");
  chk_pad_value: assert property (
    state_r == ST_PFILL |-> buf_we && buf_wd == PAD_BYTE)
    else $error("short page not padded");
  chk_prog_range: assert property (
    prog_req |-> addr_r >= PROG_ADDR_LO && addr_r <= FLASH_ADDR_HI)
    else $error("program outside target blocks");
  chk_read_range: assert property (
    state_r == ST_RCHK && read_bad
    |=> tx_valid && tx_data == FAILURE_REPLY && ret_r == ST_HALT && !read_req)
    else $error("read outside flash");
  chk_close_idle: assert property (
    state_r == ST_SESSION && rx_valid && rx_data == SESSION_CLOSE_CMD
    |=> state_r == ST_IDLE)
    else $error("close did not end session");
  chk_field_msb: assert property (
    state_r == ST_MASK && rx_valid && cnt_r == MASK_LAST_BYTE
    |=> mask_w == {$past(hdr_r[7:0]), $past(rx_data)})
    else $error("mask byte order wrong");

  cov_erase: cover property (state_r == ST_ERASE && erase_done);
  cov_page: cover property (state_r == ST_PWRITE && prog_done);
  cov_read: cover property (state_r == ST_RWAIT && read_valid);
  cov_halt: cover property ($rose(halted));

endmodule

// ===== rtl/sfuc_pkg.sv
// constants and types of the serial flash update commander
// assumes one core clock; the byte-level serial channel sits outside

package sfuc_pkg;

  // ==========================================================
  // command and reply bytes
  localparam logic [7:0] CMD_SESSION_OPEN   = 8'h55;
  localparam logic [7:0] CMD_FLASH_READ     = 8'haa;
  localparam logic [7:0] CMD_ERASE          = 8'h77;
  localparam logic [7:0] CMD_PROGRAM        = 8'h88;
  localparam logic [7:0] SESSION_CLOSE_CMD  = 8'h99;
  localparam logic [7:0] SUCCESS_REPLY      = 8'h00;
  localparam logic [7:0] FAILURE_REPLY      = 8'h01;
  localparam logic [7:0] SEND_REQUEST_REPLY = 8'h11;

  // ==========================================================
  // flash geometry and field sizes
  localparam int          PAGE_BYTES     = 256;
  localparam logic [7:0]  PAD_BYTE       = 8'hff;
  localparam logic [31:0] PROG_ADDR_LO   = 32'h0000_2000;
  localparam logic [31:0] FLASH_ADDR_HI  = 32'h0007_ffff;
  localparam logic [32:0] PROG_END_MAX   = 33'h0_0008_0000;
  localparam logic [15:0] MASK_BAD_BITS  = 16'hf001;
  localparam logic [2:0]  MASK_LAST_BYTE = 3'h1;
  localparam logic [2:0]  HDR_LAST_BYTE  = 3'h7;

  // ==========================================================
  // serial line timing: 8 data, no parity, 1 stop
  localparam int         BAUD_BPS      = 9600;
  localparam int         PERIPH_CLK_HZ = 40_000_000;
  localparam logic [7:0] BIT_RATE_DIV  =
    8'(PERIPH_CLK_HZ / (32 * BAUD_BPS) - 1);

  // ==========================================================
  // sequencer states
  typedef enum logic [4:0] {
    ST_WAIT_WE, ST_IDLE, ST_SESSION, ST_MASK, ST_ECHK, ST_ERASE,
    ST_PHDR, ST_PCHK, ST_PDATA, ST_PFILL, ST_PWRITE,
    ST_RHDR, ST_RCHK, ST_RREQ, ST_RWAIT, ST_SEND, ST_HALT
  } sfuc_state_t;

endpackage

// ===== rtl/sfuc_page_mem.sv
// byte memory used as the page staging buffer
// assumes one writer and one reader on the same clock

`timescale 1ns/1ns

module sfuc_page_mem #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_r
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ==========================================================
  // storage; no reset so it maps onto a ram macro
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // registered read, one cycle latency
  always_ff @(posedge core_clk)
  begin
    if (reset)
      rd_data_r <= '0;
    else
      rd_data_r <= mem[rd_addr];
  end

endmodule

// ===== verif/sfuc_flash_model.sv
// flash engine model: erases, copies the staging page, returns read bytes
// assumes the commander drives one request at a time on core_clk

`timescale 1ns/1ns

module sfuc_flash_model (
  input  wire logic        core_clk,
  input  wire logic        fail_next,
  input  wire logic        erase_req,
  input  wire logic [15:0] erase_mask,
  output logic             erase_done,
  output logic             erase_fail,
  input  wire logic        prog_req,
  input  wire logic [31:0] prog_addr,
  output logic             prog_done,
  output logic             prog_fail,
  output logic      [7:0]  page_rd_addr,
  input  wire logic [7:0]  page_rd_data,
  input  wire logic        read_req,
  input  wire logic [31:0] read_addr,
  output logic             read_valid,
  output logic      [7:0]  read_data
);
  logic [15:0] last_mask;
  logic [31:0] last_addr;
  logic [7:0]  page_img [256];

  initial
  begin
    {erase_done, erase_fail, prog_done, prog_fail} = 4'h0;
    {read_valid, read_data, page_rd_addr} = 17'h0;
  end

  // ==========================================================
  // erase: a few cycles of work, fail only when the bench asks
  always @(posedge core_clk)
  begin
    if (erase_req === 1'b1)
    begin
      last_mask = erase_mask;
      repeat (5) @(posedge core_clk);
      erase_done <= 1'b1;
      erase_fail <= fail_next;
      @(posedge core_clk);
      erase_done <= 1'b0;
      erase_fail <= ~fail_next; // meaningless outside the done pulse
    end
  end

  // ==========================================================
  // program: copy the whole page, registered read one edge late
  always @(posedge core_clk)
  begin
    if (prog_req === 1'b1)
    begin
      last_addr = prog_addr;
      for (int i = 0; i < 256; i++)
      begin
        page_rd_addr <= i[7:0];
        @(posedge core_clk);
        @(posedge core_clk);
        #1 page_img[i] = page_rd_data;
      end
      @(posedge core_clk);
      prog_done <= 1'b1;
      prog_fail <= fail_next;
      @(posedge core_clk);
      prog_done <= 1'b0;
    end
  end

  // ==========================================================
  // read: byte derived from address so each one is distinct
  always @(posedge core_clk)
  begin
    if (read_req === 1'b1)
    begin
      repeat (3) @(posedge core_clk);
      read_valid <= 1'b1;
      read_data  <= read_addr[7:0] ^ 8'h5a;
      @(posedge core_clk);
      read_valid <= 1'b0;
      read_data  <= ~read_data;
    end
  end
endmodule

// ===== verif/testbench.sv
// self-checking bench acting as the host on the byte channel
// assumes the commander and the flash engine model are compiled first

`timescale 1ns/1ns

module testbench;
  import sfuc_pkg::*;

  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        flash_write_enable_flag = 1'b0;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        tx_ready = 1'b0;
  logic        fail_next = 1'b0;
  logic        tx_valid, erase_req, erase_done, erase_fail, prog_req;
  logic        prog_done, prog_fail, read_req, read_valid, halted;
  logic [7:0]  tx_data, bit_rate_divisor, page_rd_addr, page_rd_data;
  logic [7:0]  read_data;
  logic [15:0] erase_mask;
  logic [31:0] prog_addr, read_addr;
  int          n_errors = 0;
  int          checks = 0;
  logic [15:0] bad [4] = '{16'h0000, 16'h0001, 16'h8000, 16'h0004};

  always #25 core_clk = ~core_clk;

  sfuc_commander DUT (.core_clk(core_clk), .reset(reset),
    .flash_write_enable_flag(flash_write_enable_flag),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data),
    .bit_rate_divisor(bit_rate_divisor), .erase_req(erase_req),
    .erase_mask(erase_mask), .erase_done(erase_done),
    .erase_fail(erase_fail), .prog_req(prog_req), .prog_addr(prog_addr),
    .prog_done(prog_done), .prog_fail(prog_fail),
    .page_rd_addr(page_rd_addr), .page_rd_data(page_rd_data),
    .read_req(read_req), .read_addr(read_addr), .read_valid(read_valid),
    .read_data(read_data), .halted(halted));

  sfuc_flash_model FM (.core_clk(core_clk), .fail_next(fail_next),
    .erase_req(erase_req), .erase_mask(erase_mask),
    .erase_done(erase_done), .erase_fail(erase_fail),
    .prog_req(prog_req), .prog_addr(prog_addr), .prog_done(prog_done),
    .prog_fail(prog_fail), .page_rd_addr(page_rd_addr),
    .page_rd_data(page_rd_data), .read_req(read_req),
    .read_addr(read_addr), .read_valid(read_valid),
    .read_data(read_data));

  // ==========================================================
  // closing and comparison helpers
  task automatic end_of_test();
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // host side of the byte channel
  task automatic send(input logic [7:0] b);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_data  <= b;
    @(posedge core_clk);
    rx_valid <= 1'b0;
  endtask

  // multi-byte fields go out most significant byte first
  task automatic send32(input logic [31:0] v);
    for (int i = 3; i >= 0; i--)
      send(v[8*i +: 8]);
  endtask

  // bounded wait, compare, then accept with one tx_ready cycle
  task automatic expect_tx(input logic [7:0] exp);
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1 n++;
    end
    while (tx_valid !== 1'b1 && n < 3000);
    chk({23'h0, tx_valid, tx_data}, {24'h1, exp});
    @(posedge core_clk);
    tx_ready <= 1'b1;
    @(posedge core_clk);
    tx_ready <= 1'b0;
    // let the accepting edge settle before any status is looked at
    #1;
  endtask

  // silence check: a stray reply would show as tx_valid high
  task automatic no_tx(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      #1 chk({31'h0, tx_valid}, 32'h0);
    end
  endtask

  task automatic restart();
    @(posedge core_clk);
    reset <= 1'b1;
    flash_write_enable_flag <= 1'b0;
    fail_next <= 1'b0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
  endtask

  // ==========================================================
  // watchdog sized well above the longest sequence
  initial
  begin
    #(50 * 40000);
    n_errors++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    restart();
    no_tx(20);
    chk(bit_rate_divisor, 32'd129);
    @(posedge core_clk);
    flash_write_enable_flag <= 1'b1;
    expect_tx(SEND_REQUEST_REPLY);
    send(CMD_ERASE);
    no_tx(10);
    send(CMD_SESSION_OPEN);
    expect_tx(SEND_REQUEST_REPLY);
    send(CMD_ERASE);
    send(8'h00);
    send(8'h02);
    expect_tx(SUCCESS_REPLY);
    chk(FM.last_mask, 32'h0002);
    send(CMD_PROGRAM);
    send32(32'h0000_2000);
    send32(32'h0000_0102);
    expect_tx(SEND_REQUEST_REPLY);
    for (int i = 0; i < 256; i++)
      send(i[7:0]);
    expect_tx(SEND_REQUEST_REPLY);
    chk(FM.last_addr, 32'h0000_2000);
    chk(FM.page_img[255], 32'hff);
    send(8'h3c);
    send(8'hc3);
    expect_tx(SUCCESS_REPLY);
    chk(FM.last_addr, 32'h0000_2100);
    chk({FM.page_img[0], FM.page_img[1]}, 32'h3cc3);
    chk({FM.page_img[2], FM.page_img[255]}, 32'hffff);
    // zero size program is finished at once
    send(CMD_PROGRAM);
    send32(32'h0000_2000);
    send32(32'h0000_0000);
    expect_tx(SUCCESS_REPLY);
    send(SESSION_CLOSE_CMD);
    send(CMD_FLASH_READ);
    expect_tx(SEND_REQUEST_REPLY);
    send32(32'h0000_0010);
    send32(32'h0000_0003);
    for (int k = 0; k < 3; k++)
      expect_tx(8'(8'h10 + k) ^ 8'h5a);
    // zero length read returns to idle without a reply
    send(CMD_FLASH_READ);
    expect_tx(SEND_REQUEST_REPLY);
    send32(32'h0000_0010);
    send32(32'h0000_0000);
    no_tx(10);
    send(CMD_FLASH_READ);
    expect_tx(SEND_REQUEST_REPLY);
    send32(32'h0008_0000);
    send32(32'h0000_0001);
    expect_tx(FAILURE_REPLY);
    chk({31'h0, halted}, 32'h1);
    send(CMD_SESSION_OPEN);
    no_tx(20);
    // bad masks, then a mask that is fine but whose erase fails
    for (int k = 0; k < 4; k++)
    begin
      restart();
      @(posedge core_clk);
      flash_write_enable_flag <= 1'b1;
      fail_next <= (k == 3);
      expect_tx(SEND_REQUEST_REPLY);
      send(CMD_SESSION_OPEN);
      expect_tx(SEND_REQUEST_REPLY);
      send(CMD_ERASE);
      send(bad[k][15:8]);
      send(bad[k][7:0]);
      expect_tx(FAILURE_REPLY);
      chk({31'h0, halted}, 32'h1);
      send(CMD_FLASH_READ);
      no_tx(20);
    end
    // program reaching into the boot block, then a failing page write
    for (int k = 0; k < 2; k++)
    begin
      restart();
      @(posedge core_clk);
      flash_write_enable_flag <= 1'b1;
      fail_next <= (k == 1);
      expect_tx(SEND_REQUEST_REPLY);
      send(CMD_SESSION_OPEN);
      expect_tx(SEND_REQUEST_REPLY);
      send(CMD_PROGRAM);
      send32(k == 0 ? 32'h0000_1f00 : 32'h0000_2000);
      send32(32'h0000_0001);
      if (k == 1)
      begin
        expect_tx(SEND_REQUEST_REPLY);
        send(8'h5a);
      end
      expect_tx(FAILURE_REPLY);
      chk({31'h0, halted}, 32'h1);
    end
    end_of_test();
  end
endmodule
